// [hw/wsa_top.v]
// Waveform engine single-access registers, ready input logic, abort and control endpoint buffer
// Overview of operation
// - Triggering low byte access starts a transaction
// - Peek register read-only, no transaction started
// - Firmware ready bit forces all six ready inputs high
// - Sync select zero: two flip-flop synchroniser
// - Sync select one: single flip-flop
// - Count expiry may replace ready pin five
// - Ready state shows pins, bits 7:6 zero
// - Writing 0xff to abort returns engine idle
// - Byte access to control endpoint buffer
// - Config resets zero, bits 4:0 read zero
// - High byte holds fifo data bits 15:8
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "wsa_consts.vh"
module wsa_top
(
	// APB
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Fifo data bus, output enable low while driving
	input  wire [15:0] fifo_data_in,
	output reg  [15:0] fifo_data_out,
	output reg         fifo_data_oe_n,
	// Ready inputs and count expiry
	input  wire [5:0]  ready_pins,
	input  wire        count_expired,
	// Engine view
	output reg  [5:0]  decision_ready,
	output reg         engine_busy,
	output reg         engine_strobe
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_WRITE = 2'd1;
	localparam ST_READ  = 2'd2;

	reg  [7:0]  cfg_q;
	reg  [7:0]  data_low_q;
	reg  [7:0]  data_high_q;
	reg  [1:0]  state_q;
	reg  [3:0]  cnt_q;
	reg  [`WSA_EP0_AW-1:0] ep0_ptr_q;
	reg  [7:0]  ep0_mem [0:`WSA_EP0_DEPTH-1];
	reg  [7:0]  rd_d;
	reg         hit_d;
	wire [5:0]  ready_sync;
	wire        access;
	wire [15:0] idx;
	wire        wr;
	wire        rd;

	function is_reg;
		input [15:0] a;
		input [15:0] r;
		begin
			is_reg = (a == r);
		end
	endfunction

	assign access = psel && penable && !pready && ce;
	assign idx    = paddr[17:2];
	assign wr     = access && pwrite;
	assign rd     = access && !pwrite;

	wsa_ready_sync u_sync
	(
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (ce),
		.sync_sel   (cfg_q[`WSA_CFG_SYNC_SEL]),
		.ready_pins (ready_pins),
		.ready_q    (ready_sync)
	);

	// Read mux and address decode
	always @*
	begin
		rd_d  = 8'h00;
		hit_d = 1'b1;
		if (is_reg(idx, `WSA_IDX_TRIGGER))
			rd_d = data_low_q;
		else if (is_reg(idx, `WSA_IDX_PEEK))
			rd_d = data_low_q;
		else if (is_reg(idx, `WSA_IDX_HIGH))
			rd_d = data_high_q;
		else if (is_reg(idx, `WSA_IDX_READY_CFG))
			rd_d = {cfg_q[7:5], 5'h00};
		else if (is_reg(idx, `WSA_IDX_READY_STATE))
			rd_d = {2'b00, ready_sync};
		else if (is_reg(idx, `WSA_IDX_ABORT))
			rd_d = 8'h00;
		else if (is_reg(idx, `WSA_IDX_EP0_DATA))
			rd_d = ep0_mem[ep0_ptr_q];
		else if (is_reg(idx, `WSA_IDX_EP0_PTR))
			rd_d = {2'b00, ep0_ptr_q};
		else if (is_reg(idx, `WSA_IDX_ENG_STATUS))
			rd_d = {6'h00, state_q};
		else
			hit_d = 1'b0;
	end

	// Bus answer: access phase with one wait state
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else if (ce)
		begin
			pready  <= psel && penable && !pready;
			pslverr <= access && !hit_d;
			if (rd)
				prdata <= {24'h000000, rd_d};
		end
	end

	// Endpoint buffer storage has no reset
	always @(posedge pclk)
	begin
		if (ce && wr && is_reg(idx, `WSA_IDX_EP0_DATA))
			ep0_mem[ep0_ptr_q] <= pwdata[7:0];
	end

	// Registers and engine sequencer
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_q          <= `WSA_CFG_RESET;
			data_low_q     <= 8'h00;
			data_high_q    <= 8'h00;
			state_q        <= ST_IDLE;
			cnt_q          <= 4'h0;
			ep0_ptr_q      <= {`WSA_EP0_AW{1'b0}};
			fifo_data_out  <= 16'h0000;
			fifo_data_oe_n <= 1'b1;
			decision_ready <= 6'h00;
			engine_busy    <= 1'b0;
			engine_strobe  <= 1'b0;
		end
		else if (ce)
		begin
			decision_ready <= {cfg_q[`WSA_CFG_TC_READY] ? count_expired : ready_sync[5],
				ready_sync[4:0]} | {6{cfg_q[`WSA_CFG_FW_READY]}};
			engine_strobe <= 1'b0;
			if (wr && is_reg(idx, `WSA_IDX_READY_CFG))
				cfg_q <= pwdata[7:0] & `WSA_CFG_WMASK;
			if (wr && is_reg(idx, `WSA_IDX_HIGH))
				data_high_q <= pwdata[7:0];
			if (access && is_reg(idx, `WSA_IDX_EP0_DATA))
				ep0_ptr_q <= ep0_ptr_q + 1'b1;
			else if (wr && is_reg(idx, `WSA_IDX_EP0_PTR))
				ep0_ptr_q <= pwdata[`WSA_EP0_AW-1:0];
			if (wr && is_reg(idx, `WSA_IDX_ABORT) && pwdata[7:0] == `WSA_ABORT_CMD)
			begin
				state_q        <= ST_IDLE;
				engine_busy    <= 1'b0;
				fifo_data_oe_n <= 1'b1;
				cnt_q          <= 4'h0;
			end
			else
			begin
				case (state_q)
					ST_IDLE:
					begin
						if (access && is_reg(idx, `WSA_IDX_TRIGGER))
						begin
							cnt_q       <= `WSA_XFER_CYCLES;
							engine_busy <= 1'b1;
							if (pwrite)
							begin
								data_low_q     <= pwdata[7:0];
								fifo_data_out  <= {data_high_q, pwdata[7:0]};
								fifo_data_oe_n <= 1'b0;
								state_q        <= ST_WRITE;
							end
							else
								state_q <= ST_READ;
						end
					end
					ST_WRITE, ST_READ:
					begin
						if (cnt_q == 4'h1)
						begin
							if (state_q == ST_READ)
							begin
								data_low_q  <= fifo_data_in[7:0];
								data_high_q <= fifo_data_in[15:8];
							end
							engine_strobe  <= 1'b1;
							engine_busy    <= 1'b0;
							fifo_data_oe_n <= 1'b1;
							state_q        <= ST_IDLE;
						end
						cnt_q <= cnt_q - 4'h1;
					end
					default:
						state_q <= ST_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [pkg/wsa_consts.vh]
// Register map, field positions, reset values and timing counts of the single-access block
`ifndef WSA_CONSTS_VH
`define WSA_CONSTS_VH
// Printed offsets are not multiples of four: they are register indices, byte address = 4 * index
`define WSA_IDX_PEEK        16'he6f2
`define WSA_IDX_READY_STATE 16'he6f4
`define WSA_IDX_TRIGGER     16'he6f1
`define WSA_IDX_HIGH        16'he6f0
`define WSA_IDX_READY_CFG   16'he6f3
`define WSA_IDX_ABORT       16'he6f5
`define WSA_IDX_EP0_DATA    16'he6f6
`define WSA_IDX_EP0_PTR     16'he6f7
`define WSA_IDX_ENG_STATUS  16'he6f8
`define WSA_IDX_ENG_CTRL    16'he6f9
// Ready configuration fields
`define WSA_CFG_FW_READY    7
`define WSA_CFG_SYNC_SEL    6
`define WSA_CFG_TC_READY    5
`define WSA_CFG_RESET       8'h00
`define WSA_CFG_WMASK       8'he0
// Abort command value
`define WSA_ABORT_CMD       8'hff
// Control endpoint buffer depth
`define WSA_EP0_DEPTH       64
`define WSA_EP0_AW          6
// Length of one waveform transaction, in interface clock cycles
`define WSA_XFER_CYCLES     4'h4
`endif

// [hw/wsa_ready_sync.v]
// Ready input synchronizer with selectable one or two stages
`timescale 1ns/1ps
`default_nettype none
module wsa_ready_sync
(
	// Clock and reset
	input  wire       pclk,
	input  wire       presetn,
	input  wire       ce,
	// Control
	input  wire       sync_sel,
	// Ready pins in, synchronised ready out
	input  wire [5:0] ready_pins,
	output reg  [5:0] ready_q
);
	reg [5:0] stage1_q;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage1_q <= 6'h00;
			ready_q  <= 6'h00;
		end
		else if (ce)
		begin
			stage1_q <= ready_pins;
			if (sync_sel)
				ready_q <= ready_pins;
			else
				ready_q <= stage1_q;
		end
	end
endmodule
`default_nettype wire

// [bench/wsa_assertions.sv]
// Port assertions for the single-access block
`timescale 1ns/1ps
`default_nettype none
module wsa_chk(
	input wire        pclk, presetn, psel, penable, pwrite, pready,
	input wire        fifo_data_oe_n, engine_busy, engine_strobe,
	input wire [31:0] paddr, pwdata,
	input wire [5:0]  ready_pins, decision_ready
);
	logic [7:0] cfg_q;
	wire acc = psel && penable && !pready;
	wire abt = acc && pwrite && paddr == 32'h39bd4 && pwdata[7:0] == 8'hff;
	wire [2:0] cm = cfg_q[7:5];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			cfg_q <= 8'h00;
		else if (acc && pwrite && paddr == 32'h39bcc)
			cfg_q <= pwdata[7:0];
	a_trig_start: assert property (acc && paddr == 32'h39bc4 && !engine_busy |=> engine_busy)
		else $error("no start");
	a_peek_quiet: assert property (acc && paddr == 32'h39bc8 && !engine_busy |=> !engine_busy)
		else $error("peek started");
	a_abort_idle: assert property (abt |=> !engine_busy && fifo_data_oe_n && !engine_strobe)
		else $error("abort");
	a_strobe_end: assert property (engine_strobe |-> !engine_busy && $past(engine_busy))
		else $error("strobe");
	a_end_strobe: assert property ($fell(engine_busy) |-> engine_strobe || $past(abt))
		else $error("end");
	a_oe_busy: assert property (!fifo_data_oe_n |-> engine_busy)
		else $error("oe");
	a_fw_ready: assert property (cfg_q[7] |=> decision_ready == 6'h3f)
		else $error("fw ready");
	a_two_flops: assert property (cm == 0 && $past(cm, 3) == 0 |-> decision_ready == $past(ready_pins, 3))
		else $error("two");
	a_one_flop: assert property (cm == 2 && $past(cm, 2) == 2 |-> decision_ready == $past(ready_pins, 2))
		else $error("one");
endmodule
bind wsa_top wsa_chk wsa_chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .fifo_data_oe_n(fifo_data_oe_n), .engine_busy(engine_busy),
	.engine_strobe(engine_strobe), .paddr(paddr), .pwdata(pwdata), .ready_pins(ready_pins),
	.decision_ready(decision_ready));
`default_nettype wire

// [bench/wsa_periph.sv]
// Peripheral on the fifo data bus and ready pins
`timescale 1ns/1ps
`default_nettype none
module wsa_periph(
	input wire         pclk, oe_n,
	input wire  [15:0] dout, rd_val,
	input wire  [5:0]  rdy_val,
	output logic [15:0] din, seen,
	output logic [5:0]  rdy
);
	initial {din, seen, rdy} = '0;
	always @(posedge pclk)
	begin
		rdy <= rdy_val;
		din <= oe_n ? rd_val : ~din; // Bus not ours while driven: keep it moving
		if (!oe_n)
			seen <= dout;
	end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the single-access block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, count_expired = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, r;
	logic pready, pslverr, fifo_data_oe_n, engine_busy, engine_strobe;
	logic [15:0] fifo_data_in, fifo_data_out, seen, rd_val = 0;
	logic [5:0] ready_pins, decision_ready, rdy_val = 0;
	logic err_r = 0;
	int num_errors = 0, total_checks = 0, n_str = 0;
	wsa_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fifo_data_in(fifo_data_in), .fifo_data_out(fifo_data_out),
		.fifo_data_oe_n(fifo_data_oe_n), .ready_pins(ready_pins), .count_expired(count_expired),
		.decision_ready(decision_ready), .engine_busy(engine_busy), .engine_strobe(engine_strobe));
	// Counts completion strobes, sampled mid-cycle where they are settled
	always @(negedge pclk)
		if (engine_strobe === 1'b1)
			n_str++;
	wsa_periph per_u (.pclk(pclk), .oe_n(fifo_data_oe_n), .dout(fifo_data_out), .rd_val(rd_val),
		.rdy_val(rdy_val), .din(fifo_data_in), .seen(seen), .rdy(ready_pins));
	initial forever #20 pclk = ~pclk;
	task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {14'h0, i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		@(negedge pclk);
		while (pready !== 1'b1)
			@(negedge pclk);
		r = prdata;
		err_r = pslverr;
		@(posedge pclk);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic rd(input logic [15:0] i, input logic [31:0] e, input string n);
		apb(0, i, 0);
		chk(n, r, e);
	endtask
	task automatic wx;
		repeat (20)
		begin
			@(negedge pclk);
			if (engine_strobe === 1'b1)
				break;
		end
		chk("strobe", {31'h0, engine_strobe}, 32'h1);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#100us;
		num_errors++;
		stop_test;
	end
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		rd(16'he6f3, 0, "cfg");
		apb(1, 16'he6f3, 8'h1f);
		rd(16'he6f3, 0, "cfg ro");
		rdy_val <= 6'h2a;
		repeat (5) @(posedge pclk);
		rd(16'he6f4, 32'h2a, "state");
		rd(16'he6f9, 0, "unmapped");
		chk("slverr", {31'h0, err_r}, 32'h1);
		$display("test config over");
		apb(1, 16'he6f0, 8'h12);
		apb(1, 16'he6f1, 8'h34);
		wx;
		chk("bus", {16'h0, seen}, 32'h1234);
		rd_val <= 16'habcd;
		apb(0, 16'he6f1, 0);
		wx;
		apb(1, 16'he6f2, 8'h55);
		rd(16'he6f2, 32'hcd, "peek");
		rd(16'he6f0, 32'hab, "high");
		apb(1, 16'he6f1, 8'h00);
		apb(1, 16'he6f5, 8'hff);
		rd(16'he6f8, 0, "status");
		repeat (8) @(negedge pclk);
		chk("strobes", n_str, 32'h2);
		$display("test engine over");
		apb(1, 16'he6f3, 8'h80);
		repeat (3) @(negedge pclk);
		chk("fw", {26'h0, decision_ready}, 32'h3f);
		apb(1, 16'he6f3, 8'h20);
		count_expired <= 1;
		rdy_val <= 0;
		repeat (5) @(negedge pclk);
		chk("tc", {26'h0, decision_ready}, 32'h20);
		apb(1, 16'he6f3, 8'h40);
		rdy_val <= 6'h15;
		rd(16'he6f4, 32'h15, "sync1");
		apb(1, 16'he6f3, 8'he0);
		rd(16'he6f3, 32'he0, "cfg rw");
		apb(1, 16'he6f7, 0);
		apb(1, 16'he6f6, 8'h5a);
		apb(1, 16'he6f6, 8'ha5);
		apb(1, 16'he6f7, 0);
		rd(16'he6f6, 32'h5a, "ep0 a");
		rd(16'he6f6, 32'ha5, "ep0 b");
		$display("test ready over");
		stop_test;
	end
endmodule
`default_nettype wire
